// ==== core/brpa_defines.vh ====
// Constants for the beacon reply pulse assembler: sequencer addresses, timing, codes.
// Assumes a 20 MHz core clock; the sequencer steps on a 4 MHz enable from a divider.
`ifndef BRPA_DEFINES_VH
`define BRPA_DEFINES_VH

`define BRPA_CLK_PERIOD_NS   50
`define BRPA_STEP_PERIOD_NS  250
`define BRPA_STEP_DIV        (`BRPA_STEP_PERIOD_NS / `BRPA_CLK_PERIOD_NS)
`define BRPA_SEQ_PULSE_NS    500
`define BRPA_SEQ_PULSE_STEPS (`BRPA_SEQ_PULSE_NS / `BRPA_STEP_PERIOD_NS)
`define BRPA_DELAY_STEP_NS   50
`define BRPA_DELAY_MAX_NS    200
`define BRPA_DELAY_TAPS      (`BRPA_DELAY_MAX_NS / `BRPA_DELAY_STEP_NS)

`define BRPA_ADDR_LONG       10'd23
`define BRPA_ADDR_SHORT      10'd247
`define BRPA_ADDR_LEG_IDENT  10'd407
`define BRPA_ADDR_LEG_PLAIN  10'd425
`define BRPA_ADDR_END        10'd512

`define BRPA_PREAMBLE_STEPS  10'd32
`define BRPA_CLEAR_STEP      10'd30
`define BRPA_MSG_BITS_LONG   8'd88
`define BRPA_MSG_BITS_SHORT  8'd32
`define BRPA_PAR_BITS        8'd24
`define BRPA_WORD_BITS       16

`define BRPA_CODE_LONG       4'h1
`define BRPA_CODE_ALLCALL    4'h2
`define BRPA_CODE_SURV       4'h3
`define BRPA_CODE_LEG_IDENT  4'h4
`define BRPA_CODE_LEG_PLAIN  4'h5

`define BRPA_PARITY_POLY     24'hFFF_409
`define BRPA_FIFO_DEPTH      32

`endif

// ==== core/brpa_assembler.v ====
// Reply assembler: sequencer, shift and parity registers, position and amplitude
// modulators, plus the word FIFO standing in for the second-stage buffer.
// Assumes trigger arrives asynchronously; data words and control code share clk.
`timescale 1ns/10ps
`default_nettype none
`include "brpa_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module brpa_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW:0]      wrPtr_ff;
  reg  [AW:0]      rdPtr_ff;
  wire             full;
  wire             empty;
  wire             push;
  wire             pop;

  assign full     = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
  assign empty    = (wrPtr_ff == rdPtr_ff);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign push     = inValid & ~full;
  assign pop      = outReady & ~empty;
  assign outData  = mem[rdPtr_ff[AW-1:0]];

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_ff <= {(AW+1){1'b0}};
      rdPtr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop)
      begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end
endmodule // brpa_fifo

////////////////////////////////////////////////////////////////////////////////
module brpa_assembler (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        triggerIn,
  input  wire [3:0]  replyCode,
  input  wire [23:0] addressBits,
  input  wire [15:0] wordIn,
  input  wire        wordInValid,
  output wire        wordInReady,
  output reg         replyPulse_ff,
  output reg         replyActive_ff,
  output reg         replyLegacy_ff,
  output reg         bufClear_ff,
  output reg         underrun_ff
);
  localparam KIND_LONG  = 2'd0;
  localparam KIND_SHORT = 2'd1;
  localparam KIND_LEG   = 2'd2;

  // Returns {hit, index[3:0], tap[2:0]} for a legacy step offset
  function [7:0] legTable;
    input [9:0] rel;
    begin
      case (rel)
        10'd0:   legTable = {1'b1, 4'd0,  3'd0};
        10'd5:   legTable = {1'b1, 4'd1,  3'd4};
        10'd11:  legTable = {1'b1, 4'd2,  3'd3};
        10'd17:  legTable = {1'b1, 4'd3,  3'd2};
        10'd23:  legTable = {1'b1, 4'd4,  3'd1};
        10'd29:  legTable = {1'b1, 4'd5,  3'd0};
        10'd34:  legTable = {1'b1, 4'd6,  3'd4};
        10'd40:  legTable = {1'b1, 4'd7,  3'd3};
        10'd46:  legTable = {1'b1, 4'd8,  3'd2};
        10'd52:  legTable = {1'b1, 4'd9,  3'd1};
        10'd58:  legTable = {1'b1, 4'd10, 3'd0};
        10'd63:  legTable = {1'b1, 4'd11, 3'd4};
        10'd69:  legTable = {1'b1, 4'd12, 3'd3};
        10'd75:  legTable = {1'b1, 4'd13, 3'd2};
        10'd81:  legTable = {1'b1, 4'd14, 3'd1};
        10'd98:  legTable = {1'b1, 4'd15, 3'd3};
        default: legTable = 8'd0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser and rising-edge detect
  reg         trigMeta_ff;
  reg         trigSync_ff;
  reg         trigPrev_ff;
  wire        trigRise;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigMeta_ff <= 1'b0;
      trigSync_ff <= 1'b0;
      trigPrev_ff <= 1'b0;
    end
    else
    begin
      trigMeta_ff <= triggerIn;
      trigSync_ff <= trigMeta_ff;
      trigPrev_ff <= trigSync_ff;
    end
  end
  assign trigRise = trigSync_ff & ~trigPrev_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Start-address selection from the control code
  reg  [9:0]  startAddr;
  reg  [1:0]  startKind;
  reg         codeValid;

  always @*
  begin
    startAddr = `BRPA_ADDR_END;
    startKind = KIND_LONG;
    codeValid = 1'b1;
    case (replyCode)
      `BRPA_CODE_LONG:
      begin
        startAddr = `BRPA_ADDR_LONG;
        startKind = KIND_LONG;
      end
      `BRPA_CODE_ALLCALL, `BRPA_CODE_SURV:
      begin
        startAddr = `BRPA_ADDR_SHORT;
        startKind = KIND_SHORT;
      end
      `BRPA_CODE_LEG_IDENT:
      begin
        startAddr = `BRPA_ADDR_LEG_IDENT;
        startKind = KIND_LEG;
      end
      `BRPA_CODE_LEG_PLAIN:
      begin
        startAddr = `BRPA_ADDR_LEG_PLAIN;
        startKind = KIND_LEG;
      end
      default:
      begin
        codeValid = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: address counter stepping on the 4 MHz enable
  reg  [2:0]  divCnt_ff;
  reg  [9:0]  seqAddr_ff;
  reg  [9:0]  base_ff;
  reg  [1:0]  kind_ff;
  reg         stepStart_ff;
  wire        tick;
  wire        startReq;
  wire [31:0] stepLast;

  assign stepLast = `BRPA_STEP_DIV - 1;
  assign tick     = replyActive_ff && (divCnt_ff == stepLast[2:0]);
  // A trigger during a reply is ignored; the running reply is never cut short
  assign startReq = trigRise && !replyActive_ff && codeValid;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_ff      <= 3'd0;
      seqAddr_ff     <= 10'd0;
      base_ff        <= 10'd0;
      kind_ff        <= KIND_LONG;
      replyActive_ff <= 1'b0;
      replyLegacy_ff <= 1'b0;
      stepStart_ff   <= 1'b0;
    end
    else
    begin
      stepStart_ff <= startReq | tick;
      if (startReq)
      begin
        divCnt_ff      <= 3'd0;
        seqAddr_ff     <= startAddr;
        base_ff        <= startAddr;
        kind_ff        <= startKind;
        replyActive_ff <= 1'b1;
        replyLegacy_ff <= (startKind == KIND_LEG);
      end
      else if (tick)
      begin
        divCnt_ff <= 3'd0;
        if (seqAddr_ff == `BRPA_ADDR_END)
        begin
          replyActive_ff <= 1'b0;
        end
        else
        begin
          seqAddr_ff <= seqAddr_ff + 10'd1;
        end
      end
      else if (replyActive_ff)
      begin
        divCnt_ff <= divCnt_ff + 3'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Step decode shared by both reply classes
  wire [9:0]  rel;
  wire [9:0]  bitRel;
  wire [7:0]  bitIdx;
  wire [1:0]  subStep;
  wire [7:0]  msgBits;
  wire        inBits;
  wire        inPreamble;
  wire [7:0]  legEntry;
  wire        legHit;
  wire        isLegacy;

  assign isLegacy   = (kind_ff == KIND_LEG);
  assign rel        = seqAddr_ff - base_ff;
  assign bitRel     = rel - `BRPA_PREAMBLE_STEPS;
  assign bitIdx     = bitRel[9:2];
  assign subStep    = bitRel[1:0];
  assign msgBits    = (kind_ff == KIND_LONG) ? `BRPA_MSG_BITS_LONG : `BRPA_MSG_BITS_SHORT;
  assign inPreamble = replyActive_ff && !isLegacy && (rel < `BRPA_PREAMBLE_STEPS);
  assign inBits     = replyActive_ff && !isLegacy && !inPreamble
                      && (bitIdx < (msgBits + `BRPA_PAR_BITS));
  assign legEntry   = legTable(rel);
  assign legHit     = replyActive_ff && isLegacy && legEntry[7];

  // Load line of the sequencer: high steps load, low steps shift
  wire        daLoad;
  wire        daShift;
  wire        legLoad;
  wire        popReq;

  assign daLoad  = stepStart_ff && inBits && (subStep == 2'd0)
                   && (bitIdx < msgBits) && (bitIdx[3:0] == 4'd0);
  assign daShift = stepStart_ff && inBits && (subStep == 2'd0)
                   && (bitIdx < msgBits) && (bitIdx[3:0] != 4'd0);
  assign legLoad = stepStart_ff && legHit && (legEntry[6:3] == 4'd0);
  assign popReq  = daLoad | legLoad;

  ////////////////////////////////////////////////////////////////////////////////
  // Word buffer in the data path
  wire [15:0] bufData;
  wire        bufValid;

  brpa_fifo #(
    .WIDTH    (`BRPA_WORD_BITS),
    .DEPTH    (`BRPA_FIFO_DEPTH),
    .AW       (5)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (wordIn),
    .inValid  (wordInValid),
    .inReady  (wordInReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (popReq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shift register and parity register
  reg  [15:0] shreg_ff;
  reg  [23:0] parity_ff;
  reg         msgSel_ff;
  wire        serialBit;
  wire [15:0] loadWord;
  wire        parFb;

  // An empty buffer loads zeros so the frame still completes on time
  assign loadWord  = bufValid ? bufData : 16'h0000;
  assign serialBit = msgSel_ff ? parity_ff[23] : shreg_ff[15];
  assign parFb     = shreg_ff[15] ^ parity_ff[23];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg_ff    <= 16'h0000;
      parity_ff   <= 24'h00_0000;
      msgSel_ff   <= 1'b0;
      bufClear_ff <= 1'b0;
      underrun_ff <= 1'b0;
    end
    else
    begin
      bufClear_ff <= popReq & bufValid;
      if (startReq)
      begin
        underrun_ff <= 1'b0;
      end
      else if (popReq && !bufValid)
      begin
        underrun_ff <= 1'b1;
      end
      if (stepStart_ff && inPreamble && (rel == `BRPA_CLEAR_STEP))
      begin
        shreg_ff  <= 16'h0000;
        parity_ff <= 24'h00_0000;
        msgSel_ff <= 1'b0;
      end
      else if (popReq)
      begin
        shreg_ff <= loadWord;
      end
      else if (daShift)
      begin
        shreg_ff <= {shreg_ff[14:0], 1'b0};
      end
      else if (stepStart_ff && legHit)
      begin
        shreg_ff <= {shreg_ff[14:0], 1'b0};
      end
      if (stepStart_ff && inBits && (subStep == 2'd3) && (bitIdx < msgBits))
      begin
        parity_ff <= {parity_ff[22:0], 1'b0} ^ (parFb ? `BRPA_PARITY_POLY : 24'h00_0000);
      end
      else if (stepStart_ff && inBits && (subStep == 2'd0) && (bitIdx == msgBits))
      begin
        parity_ff <= parity_ff ^ addressBits;
        msgSel_ff <= 1'b1;
      end
      else if (stepStart_ff && inBits && (subStep == 2'd0) && (bitIdx > msgBits))
      begin
        parity_ff <= {parity_ff[22:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse-position path: preamble pulses, then one bit per four steps
  reg         ppmOut;
  reg         preLvl;
  reg         preLvl_ff;
  reg         bitsOn_ff;
  reg  [1:0]  subStepD_ff;

  always @*
  begin
    preLvl = 1'b0;
    if (inPreamble)
    begin
      case (rel)
        10'd0, 10'd1, 10'd4, 10'd5, 10'd14, 10'd15, 10'd18, 10'd19:
          preLvl = 1'b1;
        default:
          preLvl = 1'b0;
      endcase
    end
  end

  // Decode lags one clock: load and shift land at the end of a step's first
  // clock, so an undelayed decode would send the previous bit for that clock
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preLvl_ff   <= 1'b0;
      bitsOn_ff   <= 1'b0;
      subStepD_ff <= 2'd0;
    end
    else
    begin
      preLvl_ff   <= preLvl;
      bitsOn_ff   <= inBits;
      subStepD_ff <= subStep;
    end
  end

  always @*
  begin
    ppmOut = preLvl_ff;
    if (bitsOn_ff)
    begin
      ppmOut = serialBit ? (subStepD_ff < 2'd2) : (subStepD_ff >= 2'd2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse-amplitude path: 500 ns sequencer pulse, 50 ns shaping, tapped delay
  reg  [1:0]  seqPulseCnt_ff;
  reg         seqPulse_ff;
  reg         seqPulseDly_ff;
  reg  [2:0]  tapSel_ff;
  reg         legGate_ff;
  reg  [`BRPA_DELAY_TAPS:1] tapLine_ff;
  wire        shaped;
  wire [`BRPA_DELAY_TAPS:0] taps;
  wire        legOut;
  wire [3:0]  legIdx;
  wire [31:0] pulseLast;

  assign legIdx    = legEntry[6:3];
  assign pulseLast = `BRPA_SEQ_PULSE_STEPS - 1;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seqPulseCnt_ff <= 2'd0;
      seqPulse_ff    <= 1'b0;
      tapSel_ff      <= 3'd0;
      legGate_ff     <= 1'b0;
    end
    else if (stepStart_ff)
    begin
      if (legHit)
      begin
        seqPulse_ff    <= 1'b1;
        seqPulseCnt_ff <= pulseLast[1:0];
        tapSel_ff      <= legEntry[2:0];
        if ((legIdx == 4'd0) || (legIdx == 4'd14))
        begin
          legGate_ff <= 1'b1;
        end
        else if (legIdx == 4'd15)
        begin
          // Only reachable from the earlier start address
          legGate_ff <= 1'b1;
        end
        else
        begin
          legGate_ff <= shreg_ff[14];
        end
      end
      else if (seqPulseCnt_ff != 2'd0)
      begin
        seqPulseCnt_ff <= seqPulseCnt_ff - 2'd1;
      end
      else
      begin
        seqPulse_ff <= 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seqPulseDly_ff <= 1'b0;
      tapLine_ff     <= {`BRPA_DELAY_TAPS{1'b0}};
    end
    else
    begin
      seqPulseDly_ff <= seqPulse_ff;
      tapLine_ff     <= taps[`BRPA_DELAY_TAPS-1:0];
    end
  end

  // One clock is exactly one delay step, so the delay line is a plain shift
  assign shaped = seqPulse_ff & seqPulseDly_ff;
  assign taps   = {tapLine_ff, shaped};
  assign legOut = taps[tapSel_ff] & legGate_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Class selector and registered output
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      replyPulse_ff <= 1'b0;
    end
    else
    begin
      replyPulse_ff <= replyLegacy_ff ? legOut : (ppmOut & replyActive_ff);
    end
  end

endmodule // brpa_assembler
`default_nettype wire

// ==== verification/brpa_assembler_chk.sv ====
// Checker for the reply assembler, bound to its ports.
// Assumes one clock domain and a start three edges after the trigger is sampled.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module brpa_assembler_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       triggerIn,
  input wire logic [3:0] replyCode,
  input wire logic       replyPulse_ff,
  input wire logic       replyActive_ff,
  input wire logic       replyLegacy_ff,
  input wire logic       bufClear_ff
);
  int actCnt_ff;
  int clrCnt_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Counters restart in every idle cycle, so a reset in mid-reply leaves no stale count
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      actCnt_ff <= 0;
      clrCnt_ff <= 0;
    end
    else
    begin
      actCnt_ff <= replyActive_ff ? actCnt_ff + 1 : 0;
      clrCnt_ff <= replyActive_ff ? clrCnt_ff + int'(bufClear_ff) : 0;
    end
  end

  a_quiet_idle: assert property (
    !replyActive_ff && !$past(replyActive_ff, 2) |-> !replyPulse_ff)
    else $error("pulse outside a reply");
  a_start_on_trigger: assert property (
    $rose(replyActive_ff) |-> $past(triggerIn, 3))
    else $error("reply started without a trigger");
  a_reply_length: assert property (
    $fell(replyActive_ff) |-> actCnt_ff inside {2450, 1330, 530, 440})
    else $error("reply did not end at the last location");
  a_clear_single: assert property (
    bufClear_ff |=> !bufClear_ff)
    else $error("buffer clear wider than one cycle");
  a_clear_in_reply: assert property (
    bufClear_ff |-> replyActive_ff)
    else $error("buffer clear outside a reply");
  a_clear_count: assert property (
    $fell(replyActive_ff) |-> clrCnt_ff <= (replyLegacy_ff ? 1 : 6))
    else $error("too many word loads in one reply");
  a_class_flag: assert property (
    $rose(replyActive_ff) |=> replyLegacy_ff == (replyCode inside {4'h4, 4'h5}))
    else $error("reply class flag wrong");
  a_preamble_first: assert property (
    $rose(replyActive_ff) && replyCode inside {4'h1, 4'h2, 4'h3} |-> ##2 replyPulse_ff)
    else $error("preamble did not open the reply");
  a_legacy_width: assert property (
    $rose(replyPulse_ff) && replyLegacy_ff |-> ##1 replyPulse_ff [*8] ##1 !replyPulse_ff)
    else $error("legacy pulse not nine cycles wide");
  a_ppm_width: assert property (
    $rose(replyPulse_ff) && !replyLegacy_ff |-> ##1 replyPulse_ff [*8] ##1 replyPulse_ff)
    else $error("position pulse shorter than ten cycles");
endmodule // brpa_assembler_chk

bind brpa_assembler brpa_assembler_chk i_chk (
  .clk            (clk),
  .rst_n          (rst_n),
  .triggerIn      (triggerIn),
  .replyCode      (replyCode),
  .replyPulse_ff  (replyPulse_ff),
  .replyActive_ff (replyActive_ff),
  .replyLegacy_ff (replyLegacy_ff),
  .bufClear_ff    (bufClear_ff)
);
`default_nettype wire

// ==== verification/brpa_rf_target.sv ====
// Receiver model standing where the target generator takes the reply pulses.
// Assumes pulses come only inside a reply; reports each pulse and each reply end.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module brpa_rf_target (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        replyPulse,
  input  wire logic        replyActive,
  input  wire logic        bufClear,
  output var  logic        pulseEv_ff,
  output var  logic [15:0] pulseRel_ff,
  output var  logic [15:0] pulseWid_ff,
  output var  logic        doneEv_ff,
  output var  logic [15:0] activeLen_ff,
  output var  logic [3:0]  clearCnt_ff
);
  logic [15:0] nowCnt_ff, riseAt_ff, firstAt_ff, lenCnt_ff;
  logic [3:0]  clrCnt_ff;
  logic        prevPulse_ff, prevAct_ff, seenFirst_ff;

  // Times count from the first pulse, so start latency cannot mask a spacing fault
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {nowCnt_ff, riseAt_ff, firstAt_ff, lenCnt_ff, clrCnt_ff} <= '0;
      {prevPulse_ff, prevAct_ff, seenFirst_ff, pulseEv_ff, doneEv_ff} <= '0;
      {pulseRel_ff, pulseWid_ff, activeLen_ff, clearCnt_ff} <= '0;
    end
    else
    begin
      nowCnt_ff    <= nowCnt_ff + 16'h0001;
      prevPulse_ff <= replyPulse;
      prevAct_ff   <= replyActive;
      pulseEv_ff   <= prevPulse_ff & ~replyPulse;
      doneEv_ff    <= prevAct_ff & ~replyActive;
      if (replyPulse & ~prevPulse_ff)
        riseAt_ff <= nowCnt_ff;
      if (replyPulse & ~prevPulse_ff & ~seenFirst_ff)
        firstAt_ff <= nowCnt_ff;
      seenFirst_ff <= (replyActive & ~prevAct_ff) ? 1'b0 : (seenFirst_ff | replyPulse);
      pulseRel_ff  <= riseAt_ff - firstAt_ff;
      pulseWid_ff  <= nowCnt_ff - riseAt_ff;
      lenCnt_ff    <= replyActive ? lenCnt_ff + 16'h0001 : 16'h0000;
      clrCnt_ff    <= replyActive ? clrCnt_ff + {3'b000, bufClear} : 4'h0;
      activeLen_ff <= lenCnt_ff;
      clearCnt_ff  <= clrCnt_ff;
    end
  end
endmodule // brpa_rf_target
`default_nettype wire

// ==== verification/tb_beacon_reply_pulse_assembler.sv ====
// Testbench for the reply assembler: buffer fill, every reply class, refusals, underrun.
// Assumes the receiver model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_beacon_reply_pulse_assembler;
  typedef struct {int rel; int wid;} brpa_pulse_t;
  typedef struct {int len; int clr; logic und; logic leg;} brpa_end_t;

  logic        clk, rst_n, triggerIn, wordInValid;
  logic [3:0]  replyCode;
  logic [23:0] addressBits;
  logic [15:0] wordIn;
  wire         wordInReady, replyPulse, replyActive, replyLegacy, bufClear, underrun;
  wire         pulseEv, doneEv;
  wire  [15:0] pulseRel, pulseWid, activeLen;
  wire  [3:0]  clearCnt;
  brpa_pulse_t pq[$];
  brpa_end_t   eq[$];
  logic [15:0] mq[$];
  int          fail_count = 0;
  int          num_checks = 0;
  logic [3:0]  seqCodes [0:8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h1, 4'h1, 4'h1, 4'h2, 4'h4};

  brpa_assembler i_dut (.clk(clk), .rst_n(rst_n), .triggerIn(triggerIn),
    .replyCode(replyCode), .addressBits(addressBits), .wordIn(wordIn),
    .wordInValid(wordInValid), .wordInReady(wordInReady), .replyPulse_ff(replyPulse),
    .replyActive_ff(replyActive), .replyLegacy_ff(replyLegacy),
    .bufClear_ff(bufClear), .underrun_ff(underrun));
  brpa_rf_target i_rf (.clk(clk), .rst_n(rst_n), .replyPulse(replyPulse),
    .replyActive(replyActive), .bufClear(bufClear), .pulseEv_ff(pulseEv),
    .pulseRel_ff(pulseRel), .pulseWid_ff(pulseWid), .doneEv_ff(doneEv),
    .activeLen_ff(activeLen), .clearCnt_ff(clearCnt));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic note_err(input string msg);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
      note_err(what);
  endtask

  task automatic chk_pulse(input brpa_pulse_t e, input logic [15:0] rel, input logic [15:0] wid);
    num_checks++;
    if (rel !== 16'(e.rel) || wid !== 16'(e.wid))
      note_err($sformatf("pulse %0d wide %0d, want %0d wide %0d", rel, wid, e.rel, e.wid));
  endtask

  task automatic chk_end(input brpa_end_t e);
    num_checks++;
    if (activeLen !== 16'(e.len) || clearCnt !== 4'(e.clr) || underrun !== e.und
        || replyLegacy !== e.leg)
      note_err($sformatf("reply end len %0d loads %0d", activeLen, clearCnt));
  endtask

  // Empty buffer yields zeros and no load pulse
  function automatic logic [15:0] take_word(inout brpa_end_t e);
    e.und = e.und | (mq.size() == 0);
    e.clr = e.clr + int'(mq.size() != 0);
    return (mq.size() == 0) ? 16'h0000 : mq.pop_front();
  endfunction

  task automatic plan_reply(input logic [3:0] code, input logic [23:0] adr);
    brpa_end_t   e;
    bit          lv [0:520];
    logic [23:0] crc;
    logic [15:0] w;
    int          nm;
    int          s;
    logic        b;
    e = brpa_end_t'{0, 0, 1'b0, code > 4'h3};
    crc = 24'h00_0000;
    w = take_word(e);
    if (code > 4'h3)
    begin
      for (int i = 0; i < 15; i++)
        if (i == 0 || i == 14 || w[15 - i]) pq.push_back(brpa_pulse_t'{29 * i, 9});
      if (code == 4'h4) pq.push_back(brpa_pulse_t'{493, 9});
      e.len = (code == 4'h4) ? 530 : 440;
    end
    else
    begin
      nm = (code == 4'h1) ? 88 : 32;
      for (int r = 0; r < 20; r++)
        lv[r] = r inside {0, 1, 4, 5, 14, 15, 18, 19};
      for (int k = 0; k < nm + 24; k++)
      begin
        if (k < nm && k % 16 == 0 && k > 0) w = take_word(e);
        b = (k < nm) ? w[15 - k % 16] : (crc[23 - (k - nm)] ^ adr[23 - (k - nm)]);
        if (k < nm) crc = {crc[22:0], 1'b0} ^ ((b ^ crc[23]) ? 24'hff_f409 : 24'h00_0000);
        lv[32 + 4 * k + (b ? 0 : 2)] = 1'b1;
        lv[33 + 4 * k + (b ? 0 : 2)] = 1'b1;
      end
      for (int r = 0; r < 520; r++)
      begin
        if (lv[r] && (r == 0 || !lv[r - 1])) s = r;
        if (lv[r] && !lv[r + 1]) pq.push_back(brpa_pulse_t'{5 * s, 5 * (r - s + 1)});
      end
      e.len = (code == 4'h1) ? 2450 : 1330;
    end
    eq.push_back(e);
  endtask

  task automatic pulse_trigger(input logic [3:0] code, input logic [23:0] adr);
    @(posedge clk);
    replyCode <= code;
    addressBits <= adr;
    triggerIn <= 1'b1;
    repeat (4) @(posedge clk);
    triggerIn <= 1'b0;
  endtask

  task automatic do_reply(input logic [3:0] code, input bit again);
    logic [23:0] adr;
    int          n;
    adr = 24'($urandom);
    n = 0;
    plan_reply(code, adr);
    pulse_trigger(code, adr);
    // A second trigger inside a reply must change nothing
    if (again) pulse_trigger(code, adr);
    while (replyActive !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) note_err("reply never ended");
    repeat (20) @(posedge clk) chk_bit(replyActive, 1'b0, "reply restarted");
    $display("test reply code %0h done", code);
  endtask

  always @(posedge clk)
  begin
    if (pulseEv === 1'b1)
    begin
      if (pq.size() == 0) note_err("unexpected pulse");
      else chk_pulse(pq.pop_front(), pulseRel, pulseWid);
    end
    if (doneEv === 1'b1)
    begin
      if (eq.size() == 0) note_err("unexpected reply");
      else chk_end(eq.pop_front());
      chk_bit(pq.size() == 0, 1'b1, "pulses missing");
      pq.delete();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #(60000 * 50);
    note_err("run timed out");
    give_verdict();
  end

  initial
  begin
    {rst_n, triggerIn, wordInValid, replyCode, addressBits, wordIn} <= '0;
    void'($urandom(32'h6318_acca));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk_bit(replyActive | replyPulse | bufClear, 1'b0, "busy after reset");
    chk_bit(wordInReady, 1'b1, "buffer not ready after reset");
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      wordIn <= 16'($urandom);
      wordInValid <= 1'b1;
      @(posedge clk);
      chk_bit(wordInReady, 1'b1, "buffer refused early");
      mq.push_back(wordIn);
      wordInValid <= 1'b0;
    end
    @(posedge clk);
    wordInValid <= 1'b1;
    repeat (4) @(posedge clk) chk_bit(wordInReady, 1'b0, "full buffer took a word");
    wordInValid <= 1'b0;
    $display("test buffer fill done");
    foreach (seqCodes[i])
    begin
      pulse_trigger((i == 0) ? 4'h0 : 4'(i + 6), 24'h00_0000);
      repeat (20) @(posedge clk) chk_bit(replyActive, 1'b0, "bad code started");
    end
    $display("test bad codes done");
    do_reply(4'h1, 1'b1);
    foreach (seqCodes[i])
      do_reply(seqCodes[i], 1'b0);
    give_verdict();
  end
endmodule // tb_beacon_reply_pulse_assembler
`default_nettype wire
